// ---- nvt_ctrl.sv ----
/*
 * Table access and nonvolatile memory control: control register, unlock key
 * port, table latch, 22-bit table pointer, holding bytes and the self-timed
 * erase and write sequencer.
 * Assumes the CPU core, program memory and EEPROM array share CLK_SYS_I, and
 * that program memory answers a read strobe with data one cycle later.
 */
`timescale 1ns/10ps
`include "nvt_map.svh"

module nvt_ctrl #(
	parameter int PROG_CYCLES = `NVT_PROG_CYCLES
) (
	input  wire logic                 CLK_SYS_I,
	input  wire logic                 NRST_I,
	input  wire logic                 NPOR_I,
	input  wire logic [2:0]           REG_ADDR_I,
	input  wire logic [7:0]           REG_WDATA_I,
	input  wire logic                 REG_WR_I,
	input  wire logic                 REG_RD_I,
	output logic      [7:0]           REG_RDATA_O,
	input  wire logic                 TBL_REQ_I,
	input  wire logic                 TBL_WRITE_I,
	input  wire logic [1:0]           TBL_MODE_I,
	output logic                      TBL_READY_O,
	output logic                      TBL_DONE_O,
	output logic                      PM_RD_O,
	output logic      [21:0]          PM_ADDR_O,
	input  wire logic [7:0]           PM_RDATA_I,
	output logic                      NVM_START_O,
	output nvt_pkg::nvt_op_t          NVM_OP_O,
	output nvt_pkg::nvt_target_t      NVM_TGT_O,
	output logic      [15:0]          NVM_ROW_O,
	output logic                      NVM_BUSY_O,
	output logic                      PGM_WSTB_O,
	output logic      [5:0]           PGM_WIDX_O,
	output logic      [7:0]           PGM_WDATA_O,
	output logic                      EE_RD_O,
	output logic                      CPU_STALL_O
);

	localparam logic [`NVT_CNT_W-1:0] CNT_LAST = `NVT_CNT_W'(PROG_CYCLES - 1);

	logic                     pgm_sel;
	logic                     cfg_sel;
	logic                     erase_en;
	logic                     abort_flag;
	logic                     write_gate;
	logic                     wr_bit;
	logic                     rd_bit;
	logic                     done_flag;
	nvt_pkg::nvt_key_t        key_stage;
	logic [7:0]               latch;
	logic [21:0]              ptr;
	logic [`NVT_CNT_W-1:0]    cnt;
	nvt_pkg::nvt_tbl_state_t  tbl_state;
	logic                     wr_ctrl;
	logic                     start_req;
	logic                     start_ok;
	logic                     op_end;
	logic                     tbl_take;
	logic [21:0]              next_ptr;
	logic [21:0]              access_addr;
	logic [7:0]               hold_byte;
	logic                     stream_on;

	// Only the low 21 bits step, so the top bit keeps its region.
	function automatic logic [21:0] ptr_step(input logic [21:0] p, input logic down);
		ptr_step = {p[21], down ? p[20:0] - 21'h1 : p[20:0] + 21'h1};
	endfunction

	function automatic nvt_pkg::nvt_target_t target_of(input logic pgm, input logic cfg);
		if (cfg) begin
			target_of = nvt_pkg::NVT_TGT_CONFIG;
		end else if (pgm) begin
			target_of = nvt_pkg::NVT_TGT_PROGRAM;
		end else begin
			target_of = nvt_pkg::NVT_TGT_EEPROM;
		end
	endfunction

	assign wr_ctrl   = REG_WR_I && (REG_ADDR_I == `NVT_OFS_CTRL);
	assign start_req = wr_ctrl && REG_WDATA_I[`NVT_B_WR] && !wr_bit;
	// A start without the gate or without the fresh key pair is refused.
	assign start_ok  = start_req && write_gate && (key_stage == nvt_pkg::NVT_KEY_ARMED);
	assign op_end    = NVM_BUSY_O && (cnt == CNT_LAST);
	assign CPU_STALL_O = NVM_BUSY_O && (NVM_OP_O != nvt_pkg::NVT_OP_EE_WRITE);
	assign TBL_READY_O = (tbl_state == nvt_pkg::NVT_TS_IDLE) && !CPU_STALL_O;
	assign tbl_take    = TBL_REQ_I && TBL_READY_O;
	assign access_addr = (TBL_MODE_I == `NVT_MODE_PREINC) ? ptr_step(ptr, 1'b0) : ptr;
	assign stream_on   = NVM_BUSY_O && (NVM_OP_O == nvt_pkg::NVT_OP_BLOCK_WRITE)
		&& (cnt < `NVT_CNT_W'(`NVT_HOLD_BYTES));

	always_comb begin
		case (TBL_MODE_I)
			`NVT_MODE_POSTINC: next_ptr = ptr_step(ptr, 1'b0);
			`NVT_MODE_POSTDEC: next_ptr = ptr_step(ptr, 1'b1);
			`NVT_MODE_PREINC:  next_ptr = access_addr;
			default:           next_ptr = ptr;
		endcase
	end

	nvt_hold_buf i_nvt_hold_buf (
		.clk_i     (CLK_SYS_I),
		.nrst_i    (NRST_I),
		.wr_en_i   (tbl_take && TBL_WRITE_I),
		.wr_idx_i  (access_addr[5:0]),
		.wr_data_i (latch),
		.clr_i     (op_end),
		.rd_idx_i  (cnt[5:0]),
		.rd_data_o (hold_byte)
	);

	// Selects and the abort flag survive an ordinary reset so software can see
	// which operation was cut short; only power-up clears them.
	always_ff @(posedge CLK_SYS_I or negedge NPOR_I) begin
		if (!NPOR_I) begin
			pgm_sel <= 1'b0;
			cfg_sel <= 1'b0;
		end else if (wr_ctrl) begin
			pgm_sel <= REG_WDATA_I[`NVT_B_PGM_SEL];
			cfg_sel <= REG_WDATA_I[`NVT_B_CFG_SEL];
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge NPOR_I) begin
		if (!NPOR_I) begin
			abort_flag <= 1'b0;
		end else if (start_req) begin
			// Software cannot clear the flag, and a refused start marks it like a
			// real one, so only a completed cycle proves the last write good.
			abort_flag <= 1'b1;
		end else if (op_end) begin
			abort_flag <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge NRST_I or negedge NPOR_I) begin
		if (!NRST_I || !NPOR_I) begin
			write_gate <= 1'b0;
			erase_en   <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				write_gate <= REG_WDATA_I[`NVT_B_GATE];
			end
			if (op_end && (NVM_OP_O == nvt_pkg::NVT_OP_ROW_ERASE)) begin
				erase_en <= 1'b0;
			end else if (wr_ctrl) begin
				erase_en <= REG_WDATA_I[`NVT_B_ERASE_EN];
			end
		end
	end

	// Reset stops the cycle outright; the abort flag above stays as proof.
	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			wr_bit      <= 1'b0;
			NVM_BUSY_O  <= 1'b0;
			NVM_START_O <= 1'b0;
			NVM_OP_O    <= nvt_pkg::NVT_OP_EE_WRITE;
			NVM_TGT_O   <= nvt_pkg::NVT_TGT_EEPROM;
			NVM_ROW_O   <= 16'h0000;
			cnt         <= '0;
		end else begin
			NVM_START_O <= start_ok;
			if (start_ok) begin
				wr_bit     <= 1'b1;
				NVM_BUSY_O <= 1'b1;
				cnt        <= '0;
				NVM_TGT_O  <= target_of(REG_WDATA_I[`NVT_B_PGM_SEL], REG_WDATA_I[`NVT_B_CFG_SEL]);
				NVM_ROW_O  <= ptr[21:6];
				if (!REG_WDATA_I[`NVT_B_PGM_SEL] && !REG_WDATA_I[`NVT_B_CFG_SEL]) begin
					NVM_OP_O <= nvt_pkg::NVT_OP_EE_WRITE;
				end else if (REG_WDATA_I[`NVT_B_ERASE_EN]) begin
					NVM_OP_O <= nvt_pkg::NVT_OP_ROW_ERASE;
				end else begin
					NVM_OP_O <= nvt_pkg::NVT_OP_BLOCK_WRITE;
				end
			end else if (op_end) begin
				wr_bit     <= 1'b0;
				NVM_BUSY_O <= 1'b0;
			end else if (NVM_BUSY_O) begin
				cnt <= cnt + `NVT_CNT_W'(1);
			end
		end
	end

	// Bytes still at the erased value are skipped so their cells stay as they are.
	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			PGM_WSTB_O  <= 1'b0;
			PGM_WIDX_O  <= 6'h00;
			PGM_WDATA_O <= 8'h00;
		end else begin
			PGM_WSTB_O  <= stream_on && (hold_byte != `NVT_HOLD_ERASED);
			PGM_WIDX_O  <= cnt[5:0];
			PGM_WDATA_O <= hold_byte;
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			rd_bit <= 1'b0;
		end else if (rd_bit) begin
			rd_bit <= 1'b0;
		end else if (wr_ctrl && REG_WDATA_I[`NVT_B_RD]) begin
			rd_bit <= !REG_WDATA_I[`NVT_B_PGM_SEL] && !REG_WDATA_I[`NVT_B_CFG_SEL];
		end
	end

	assign EE_RD_O = rd_bit;

	// Set beats a simultaneous software clear.
	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			done_flag <= 1'b0;
		end else if (op_end) begin
			done_flag <= 1'b1;
		end else if (REG_WR_I && (REG_ADDR_I == `NVT_OFS_FLAGS)) begin
			done_flag <= REG_WDATA_I[`NVT_B_DONE];
		end
	end

	// Any register write other than the expected key breaks the sequence.
	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			key_stage <= nvt_pkg::NVT_KEY_IDLE;
		end else if (REG_WR_I) begin
			if ((REG_ADDR_I == `NVT_OFS_KEY) && (REG_WDATA_I == `NVT_KEY_FIRST)) begin
				key_stage <= nvt_pkg::NVT_KEY_HALF;
			end else if ((REG_ADDR_I == `NVT_OFS_KEY) && (REG_WDATA_I == `NVT_KEY_SECOND)
				&& (key_stage == nvt_pkg::NVT_KEY_HALF)) begin
				key_stage <= nvt_pkg::NVT_KEY_ARMED;
			end else begin
				key_stage <= nvt_pkg::NVT_KEY_IDLE;
			end
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			tbl_state  <= nvt_pkg::NVT_TS_IDLE;
			PM_RD_O    <= 1'b0;
			PM_ADDR_O  <= 22'h000000;
			TBL_DONE_O <= 1'b0;
		end else begin
			PM_RD_O    <= 1'b0;
			TBL_DONE_O <= 1'b0;
			case (tbl_state)
				nvt_pkg::NVT_TS_IDLE: begin
					if (tbl_take && TBL_WRITE_I) begin
						TBL_DONE_O <= 1'b1;
					end else if (tbl_take) begin
						PM_RD_O   <= 1'b1;
						PM_ADDR_O <= access_addr;
						tbl_state <= nvt_pkg::NVT_TS_RD_ISSUE;
					end
				end
				nvt_pkg::NVT_TS_RD_ISSUE: begin
					tbl_state <= nvt_pkg::NVT_TS_RD_CAPTURE;
				end
				default: begin
					TBL_DONE_O <= 1'b1;
					tbl_state  <= nvt_pkg::NVT_TS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			latch <= `NVT_LATCH_RST;
		end else if (tbl_state == nvt_pkg::NVT_TS_RD_CAPTURE) begin
			latch <= PM_RDATA_I;
		end else if (REG_WR_I && (REG_ADDR_I == `NVT_OFS_LATCH)) begin
			latch <= REG_WDATA_I;
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			ptr <= `NVT_PTR_RST;
		end else if (tbl_take) begin
			ptr <= next_ptr;
		end else if (REG_WR_I && (REG_ADDR_I == `NVT_OFS_PTR_LOW)) begin
			ptr[7:0] <= REG_WDATA_I;
		end else if (REG_WR_I && (REG_ADDR_I == `NVT_OFS_PTR_HIGH)) begin
			ptr[15:8] <= REG_WDATA_I;
		end else if (REG_WR_I && (REG_ADDR_I == `NVT_OFS_PTR_UPPER)) begin
			ptr[21:16] <= REG_WDATA_I[5:0];
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			REG_RDATA_O <= 8'h00;
		end else if (!REG_RD_I) begin
			REG_RDATA_O <= 8'h00;
		end else if (REG_ADDR_I == `NVT_OFS_CTRL) begin
			REG_RDATA_O <= {pgm_sel, cfg_sel, 1'b0, erase_en, abort_flag, write_gate, wr_bit, rd_bit};
		end else if (REG_ADDR_I == `NVT_OFS_LATCH) begin
			REG_RDATA_O <= latch;
		end else if (REG_ADDR_I == `NVT_OFS_PTR_LOW) begin
			REG_RDATA_O <= ptr[7:0];
		end else if (REG_ADDR_I == `NVT_OFS_PTR_HIGH) begin
			REG_RDATA_O <= ptr[15:8];
		end else if (REG_ADDR_I == `NVT_OFS_PTR_UPPER) begin
			REG_RDATA_O <= {2'h0, ptr[21:16]};
		end else if (REG_ADDR_I == `NVT_OFS_FLAGS) begin
			REG_RDATA_O <= {1'b0, done_flag, 6'h00};
		end else begin
			REG_RDATA_O <= 8'h00;
		end
	end

	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!NRST_I || !NPOR_I);

	a_key_reads_zero: assert property (REG_RD_I && (REG_ADDR_I == `NVT_OFS_KEY) |=> REG_RDATA_O == 8'h00)
		else $error("unlock key port read not zero");
	a_pgm_target: assert property (NVM_START_O && !cfg_sel |-> (NVM_TGT_O == nvt_pkg::NVT_TGT_PROGRAM) == pgm_sel)
		else $error("program select not honoured");
	a_cfg_target: assert property (NVM_START_O |-> (NVM_TGT_O == nvt_pkg::NVT_TGT_CONFIG) == cfg_sel)
		else $error("config select not honoured");
	a_erase_clears: assert property (op_end && (NVM_OP_O == nvt_pkg::NVT_OP_ROW_ERASE) |=> !erase_en)
		else $error("erase enable not cleared");
	a_gate_blocks: assert property (wr_ctrl && !write_gate |=> !NVM_START_O)
		else $error("cycle started without write gate");
	a_end_flags: assert property (op_end |=> done_flag && !abort_flag && !wr_bit && !NVM_BUSY_O)
		else $error("completion flags wrong");
	a_start_sticks: assert property (wr_bit && !op_end && wr_ctrl |=> wr_bit)
		else $error("software cleared start bit");
	a_rd_one_cycle: assert property (rd_bit |=> !rd_bit)
		else $error("read start longer than one cycle");
	a_rd_refused: assert property (wr_ctrl && (REG_WDATA_I[`NVT_B_PGM_SEL] || REG_WDATA_I[`NVT_B_CFG_SEL]) |=> !rd_bit)
		else $error("read start set with a select high");
	a_ptr_top_kept: assert property (tbl_take |=> ptr[21] == $past(ptr[21]))
		else $error("pointer top bit changed by stepping");
	a_unlock_needed: assert property (NVM_START_O |-> $past(key_stage) == nvt_pkg::NVT_KEY_ARMED)
		else $error("cycle started without unlock");
	a_stall_holds: assert property ($rose(CPU_STALL_O) |-> CPU_STALL_O[*8])
		else $error("stall ended early");

	c_row_erase: cover property (op_end && (NVM_OP_O == nvt_pkg::NVT_OP_ROW_ERASE));
	c_block_write: cover property (PGM_WSTB_O ##[1:100] op_end);
	c_ee_write: cover property (op_end && (NVM_OP_O == nvt_pkg::NVT_OP_EE_WRITE));
	c_table_read: cover property (PM_RD_O ##2 TBL_DONE_O);

endmodule

// ---- nvt_map.svh ----
/*
 * Constants of the table access and nonvolatile memory control block: register
 * offsets, field positions, reset values, unlock keys, pointer modes and timing.
 * Assumes a byte-wide register port and a 100 MHz system clock.
 */
//
// Contract
// - Unlock key port always reads as zero.
// - Program select chooses flash, else data EEPROM.
// - Config select overrides program select when set.
// - Erase enable turns next flash or config start into row erase.
// - Erase enable clears itself when erase completes.
// - Write gate must be set; reset clears it.
// - Abort flag set at start, cleared on completion.
// - Abort leaves both select bits untouched.
// - Software only sets start; hardware clears it.
// - Start launches EEPROM write, row erase, block write.
// - Done flag set on completion, software clears.
// - Read start lasts one cycle, then self-clears.
// - Read start refused while any select set.
// - Eight-bit latch carries each table byte.
// - Three bytes form a 22-bit pointer.
// - Table ops: keep, post-inc, post-dec, pre-inc pointer.
// - Pointer stepping touches only low 21 bits.
// - Table read addresses with all 22 bits.
// - Table write picks holding byte by bits 5:0.
// - Block write uses pointer bits 21:6.
// - Row erase uses bits 21:6, ignores 5:0.
// - Start needs 55h then AAh key writes first.
// - CPU stalls for whole program memory cycle.
// - Holding bytes reset to FFh; FFh leaves byte alone.
`ifndef NVT_MAP_SVH
`define NVT_MAP_SVH

`define NVT_OFS_CTRL      3'h0
`define NVT_OFS_KEY       3'h1
`define NVT_OFS_LATCH     3'h2
`define NVT_OFS_PTR_LOW   3'h3
`define NVT_OFS_PTR_HIGH  3'h4
`define NVT_OFS_PTR_UPPER 3'h5
`define NVT_OFS_FLAGS     3'h6

`define NVT_B_PGM_SEL   7
`define NVT_B_CFG_SEL   6
`define NVT_B_ERASE_EN  4
`define NVT_B_ABORT     3
`define NVT_B_GATE      2
`define NVT_B_WR        1
`define NVT_B_RD        0
`define NVT_B_DONE      6

`define NVT_KEY_FIRST   8'h55
`define NVT_KEY_SECOND  8'haa
`define NVT_HOLD_ERASED 8'hff
`define NVT_LATCH_RST   8'h00
`define NVT_PTR_RST     22'h000000

`define NVT_MODE_KEEP    2'h0
`define NVT_MODE_POSTINC 2'h1
`define NVT_MODE_POSTDEC 2'h2
`define NVT_MODE_PREINC  2'h3

`define NVT_HOLD_BYTES  7'h40
`define NVT_CNT_W       17
`define NVT_CLK_NS      10
`define NVT_PROG_TIME_NS 1000000
`define NVT_PROG_CYCLES (`NVT_PROG_TIME_NS / `NVT_CLK_NS)

`endif

// ---- nvt_pkg.sv ----
/*
 * Types shared by the table access and nonvolatile memory control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package nvt_pkg;

	typedef enum logic [1:0] {NVT_TGT_EEPROM, NVT_TGT_PROGRAM, NVT_TGT_CONFIG} nvt_target_t;

	typedef enum logic [1:0] {NVT_OP_EE_WRITE, NVT_OP_ROW_ERASE, NVT_OP_BLOCK_WRITE} nvt_op_t;

	typedef enum logic [1:0] {NVT_KEY_IDLE, NVT_KEY_HALF, NVT_KEY_ARMED} nvt_key_t;

	typedef enum logic [1:0] {NVT_TS_IDLE, NVT_TS_RD_ISSUE, NVT_TS_RD_CAPTURE} nvt_tbl_state_t;

endpackage

// ---- nvt_hold_buf.sv ----
/*
 * Sixty-four programming holding bytes filled by table writes.
 * Assumes one clock domain; the reader indexes the array combinationally.
 */
`timescale 1ns/10ps
`include "nvt_map.svh"

module nvt_hold_buf (
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	input  wire logic       wr_en_i,
	input  wire logic [5:0] wr_idx_i,
	input  wire logic [7:0] wr_data_i,
	input  wire logic       clr_i,
	input  wire logic [5:0] rd_idx_i,
	output logic      [7:0] rd_data_o
);

	logic [7:0] hold [0:63];

	// Every byte returns to the erased value so untouched bytes never program.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < 64; i++) begin
				hold[i] <= `NVT_HOLD_ERASED;
			end
		end else if (clr_i) begin
			for (int i = 0; i < 64; i++) begin
				hold[i] <= `NVT_HOLD_ERASED;
			end
		end else if (wr_en_i) begin
			hold[wr_idx_i] <= wr_data_i;
		end
	end

	assign rd_data_o = hold[rd_idx_i];

endmodule

// ---- nvt_pm_model.sv ----
/*
 * Program memory model that answers the table read strobe of the controller.
 * Assumes a one-cycle read strobe and that data is taken in the following cycle.
 */
`timescale 1ns/10ps

module nvt_pm_model (
	input  wire logic        clk_i,
	input  wire logic        rd_i,
	input  wire logic [21:0] addr_i,
	output logic      [7:0]  data_o
);
	initial data_o = 8'h5a;
	// Between answers the bus toggles, so stale data never passes for a reply.
	always @(posedge clk_i) begin
		data_o <= rd_i ? (addr_i[7:0] ^ {2'h0, addr_i[21:16]}) : ~data_o;
	end
endmodule

// ---- test_nvt_ctrl.sv ----
/*
 * Self-checking bench for the table access and memory control block.
 * Assumes a 100 MHz system clock and a shortened programming time.
 */
`timescale 1ns/10ps

module test_nvt_ctrl;
	localparam int PROG = 100;
	typedef struct {logic [2:0] a; logic [7:0] w; logic [7:0] e;} nvt_row_t;

	logic                 clk = 1'b0;
	logic                 nrst = 1'b0;
	logic                 npor = 1'b0;
	logic [2:0]           ra = 3'h0;
	logic [7:0]           rw = 8'h00;
	logic                 rwr = 1'b0;
	logic                 rrd = 1'b0;
	logic                 treq = 1'b0;
	logic                 twr = 1'b0;
	logic [1:0]           tmode = 2'h0;
	logic [7:0]           rdat, pmd, wdat, d;
	logic                 tready, tdone, pmrd, nstart, nbusy, wstb, eerd, stall;
	logic [21:0]          pmaddr, p, acc, q;
	logic [15:0]          nrow;
	logic [5:0]           widx;
	logic [20:0]          cap;
	nvt_pkg::nvt_op_t     nop;
	nvt_pkg::nvt_target_t ntgt;
	logic [13:0]          hq[$];
	int                   mismatches = 0;
	int                   total_checks = 0;
	int                   starts = 0;
	int                   ee_rds = 0;
	int                   s;
	nvt_row_t rows [6] = '{'{3'h3, 8'h5a, 8'h5a}, '{3'h4, 8'hc3, 8'hc3}, '{3'h5, 8'hff, 8'h3f},
		'{3'h2, 8'ha5, 8'ha5}, '{3'h1, 8'h55, 8'h00}, '{3'h7, 8'h77, 8'h00}};
	logic [7:0] hb [3] = '{8'h11, 8'h22, 8'hff};
	logic [7:0] tc [3] = '{8'h06, 8'hc6, 8'h46};
	nvt_pkg::nvt_target_t tt [3] = '{nvt_pkg::NVT_TGT_EEPROM, nvt_pkg::NVT_TGT_CONFIG,
		nvt_pkg::NVT_TGT_CONFIG};
	nvt_pkg::nvt_op_t to [3] = '{nvt_pkg::NVT_OP_EE_WRITE, nvt_pkg::NVT_OP_BLOCK_WRITE,
		nvt_pkg::NVT_OP_BLOCK_WRITE};

	nvt_ctrl #(.PROG_CYCLES(PROG)) i_nvt_ctrl (.CLK_SYS_I(clk), .NRST_I(nrst), .NPOR_I(npor),
		.REG_ADDR_I(ra), .REG_WDATA_I(rw), .REG_WR_I(rwr), .REG_RD_I(rrd), .REG_RDATA_O(rdat),
		.TBL_REQ_I(treq), .TBL_WRITE_I(twr), .TBL_MODE_I(tmode), .TBL_READY_O(tready),
		.TBL_DONE_O(tdone), .PM_RD_O(pmrd), .PM_ADDR_O(pmaddr), .PM_RDATA_I(pmd),
		.NVM_START_O(nstart), .NVM_OP_O(nop), .NVM_TGT_O(ntgt), .NVM_ROW_O(nrow),
		.NVM_BUSY_O(nbusy), .PGM_WSTB_O(wstb), .PGM_WIDX_O(widx), .PGM_WDATA_O(wdat),
		.EE_RD_O(eerd), .CPU_STALL_O(stall));
	nvt_pm_model i_nvt_pm_model (.clk_i(clk), .rd_i(pmrd), .addr_i(pmaddr), .data_o(pmd));

	always #5 clk = ~clk;

	// Pulses are counted at the falling edge, where registered outputs have settled.
	always @(negedge clk) begin
		if (nstart === 1'b1) begin
			starts++;
			cap = {nop, ntgt, nrow, stall};
		end
		if (eerd === 1'b1)
			ee_rds++;
		if (wstb === 1'b1)
			hq.push_back({widx, wdat});
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, m, got, exp);
		end
	endtask

	task automatic reg_wr(input logic [2:0] a, input logic [7:0] w);
		ra <= a;
		rw <= w;
		rwr <= 1'b1;
		@(posedge clk);
		rwr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic reg_rd(input logic [2:0] a, output logic [7:0] r);
		ra <= a;
		rrd <= 1'b1;
		@(posedge clk);
		rrd <= 1'b0;
		@(negedge clk);
		r = rdat;
		@(posedge clk);
	endtask

	task automatic set_ptr(input logic [21:0] v);
		reg_wr(3'h3, v[7:0]);
		reg_wr(3'h4, v[15:8]);
		reg_wr(3'h5, {2'h0, v[21:16]});
	endtask

	task automatic get_ptr(output logic [21:0] v);
		logic [7:0] lo, hi, up;
		reg_rd(3'h3, lo);
		reg_rd(3'h4, hi);
		reg_rd(3'h5, up);
		v = {up[5:0], hi, lo};
	endtask

	task automatic tbl(input logic w, input logic [1:0] m);
		int n;
		twr <= w;
		tmode <= m;
		treq <= 1'b1;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (tready !== 1'b1 && n < 50);
		@(posedge clk);
		treq <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (tdone !== 1'b1 && n < 10);
		chk(tdone, 1'b1, "table done");
		@(posedge clk);
	endtask

	task automatic nvm_run(input logic [7:0] c, input nvt_pkg::nvt_op_t op,
		input nvt_pkg::nvt_target_t tg, input logic [15:0] row, input logic [7:0] after);
		int s0;
		int n;
		logic [7:0] r;
		s0 = starts;
		reg_wr(3'h1, 8'h55);
		reg_wr(3'h1, 8'haa);
		reg_wr(3'h0, c);
		chk(starts, s0 + 1, "cycle launch");
		chk(cap, {op, tg, row, op != nvt_pkg::NVT_OP_EE_WRITE}, "launch");
		reg_wr(3'h0, c & 8'hfd);
		reg_rd(3'h0, r);
		chk(r, c | 8'h08, "control while busy");
		n = 0;
		while (nbusy !== 1'b0 && n < PROG + 50) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		reg_rd(3'h0, r);
		chk(r, after, "control after cycle");
		reg_rd(3'h6, r);
		chk(r, 8'h40, "done flag set");
		reg_wr(3'h6, 8'h00);
		reg_rd(3'h6, r);
		chk(r, 8'h00, "done flag cleared");
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		#100000;
		mismatches++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		wrap_up();
	end

	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		npor <= 1'b1;
		@(posedge clk);
		foreach (rows[i]) begin
			reg_wr(rows[i].a, rows[i].w);
			reg_rd(rows[i].a, d);
			chk(d, rows[i].e, "register readback");
		end
		$display("register table done");
		p = 22'h3fffff;
		set_ptr(p);
		for (int m = 0; m < 4; m++) begin
			acc = (m == 3) ? {p[21], p[20:0] + 21'h1} : p;
			if (m == 1 || m == 3)
				p = {p[21], p[20:0] + 21'h1};
			if (m == 2)
				p = {p[21], p[20:0] - 21'h1};
			tbl(1'b0, m[1:0]);
			chk(pmaddr, acc, "read address");
			reg_rd(3'h2, d);
			chk(d, acc[7:0] ^ {2'h0, acc[21:16]}, "latch byte");
			get_ptr(q);
			chk(q, p, "pointer step");
		end
		$display("table reads done");
		s = ee_rds;
		reg_wr(3'h0, 8'h01);
		chk(ee_rds, s + 1, "read pulse");
		reg_rd(3'h0, d);
		chk(d, 8'h00, "read bit self clears");
		reg_wr(3'h0, 8'h81);
		reg_wr(3'h0, 8'h41);
		chk(ee_rds, s + 1, "read refused");
		s = starts;
		reg_wr(3'h0, 8'h86);
		reg_rd(3'h0, d);
		chk(d, 8'h8c, "start without key");
		reg_wr(3'h0, 8'h80);
		reg_wr(3'h1, 8'h55);
		reg_wr(3'h1, 8'haa);
		reg_wr(3'h0, 8'h82);
		reg_rd(3'h0, d);
		chk(d, 8'h88, "start without gate");
		reg_wr(3'h0, 8'h84);
		reg_wr(3'h1, 8'h55);
		reg_wr(3'h1, 8'haa);
		reg_wr(3'h3, 8'h00);
		reg_wr(3'h0, 8'h86);
		chk(starts, s, "refused starts");
		$display("refusals done");
		set_ptr(22'h1abcc5);
		foreach (hb[i]) begin
			reg_wr(3'h2, hb[i]);
			tbl(1'b1, 2'h1);
		end
		hq.delete();
		nvm_run(8'h86, nvt_pkg::NVT_OP_BLOCK_WRITE, nvt_pkg::NVT_TGT_PROGRAM, 16'h6af3, 8'h84);
		chk(hq.size(), 2, "programmed bytes");
		if (hq.size() == 2) begin
			chk(hq[0], {6'h05, 8'h11}, "first byte");
			chk(hq[1], {6'h06, 8'h22}, "second byte");
		end
		set_ptr(22'h00007f);
		hq.delete();
		nvm_run(8'h96, nvt_pkg::NVT_OP_ROW_ERASE, nvt_pkg::NVT_TGT_PROGRAM, 16'h0001, 8'h84);
		chk(hq.size(), 0, "holding bytes erased");
		foreach (tc[i])
			nvm_run(tc[i], to[i], tt[i], 16'h0001, tc[i] & 8'hfd);
		$display("timed cycles done");
		reg_wr(3'h1, 8'h55);
		reg_wr(3'h1, 8'haa);
		reg_wr(3'h0, 8'hc6);
		repeat (10) @(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		reg_rd(3'h0, d);
		chk(d, 8'hc8, "aborted cycle");
		chk(nbusy, 1'b0, "busy dropped");
		reg_wr(3'h0, 8'hc4);
		npor <= 1'b0;
		@(posedge clk);
		npor <= 1'b1;
		@(posedge clk);
		reg_rd(3'h0, d);
		chk(d, 8'h00, "power-up clear");
		$display("reset tests done");
		wrap_up();
	end
endmodule
